// >>> btf_pkg.sv
// Purpose: Shared constants and carrier types for breakpoint and trace-fault logic
// Assumes: 32-bit local bus addresses, word-wide register port
// Notes: Byte offsets are the printed local bus addresses
package btf_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [15:0] INSTR_BP_CH0_OFS = 16'h8400;
  localparam logic [15:0] INSTR_BP_CH1_OFS = 16'h8404;
  localparam logic [15:0] DATA_BP_CH0_OFS = 16'h8420;
  localparam logic [15:0] DATA_BP_CH1_OFS = 16'h8424;
  localparam logic [31:0] BP_RESET_VAL = 32'h0000_0000;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int INSTR_BP_ADDR_LSB = 2;
  localparam int INSTR_BP_MODE_HI = 1;
  localparam int INSTR_BP_MODE_LO = 0;
  // breakpoint_control: per data channel, enable at 4*ch+16, mode at 4*ch+18
  localparam int CTL_DATA_EN_BASE = 16;
  localparam int CTL_DATA_MODE_BASE = 18;
  localparam int CTL_CH_STRIDE = 4;
  localparam logic [1:0] BP_FIELD_OFF = 2'h0;
  localparam logic [1:0] BP_FIELD_FAULT = 2'h3;
  localparam logic [1:0] DMODE_WRITE_ONLY = 2'h0;
  localparam logic [1:0] DMODE_READ_ONLY = 2'h2;

  // ==========================================================
  // Trace event bits in a fault record
  // ==========================================================
  localparam int EV_INSTR_GROUP = 0;
  localparam int EV_FAULT_CALL = 1;
  localparam int EV_MARK = 2;
  localparam int EV_FMARK = 3;
  localparam int EV_IBP = 4;
  localparam int EV_DBP = 5;
  localparam int EV_SUPERVISOR = 6;
  localparam int EV_PRERETURN = 7;
  localparam int EV_W = 8;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [4:0] len;
  } btf_daccess_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic sysctl;
    logic [15:0] addr;
    logic [31:0] wdata;
  } btf_regreq_t;

  typedef enum logic [1:0] {
    BTF_IDLE = 2'b00,
    BTF_REPORT = 2'b01,
    BTF_PRERET = 2'b11
  } btf_state_t;

endpackage

// >>> btf_dbp_match.sv
// Purpose: One data breakpoint channel compare
// Assumes: Access covers len bytes starting at addr, len 1 to 16
// Notes: Combinational; hit is registered downstream
`timescale 1ns/1ps
module btf_dbp_match (
  input wire logic [31:0] bp_addr_i,
  input wire logic [1:0] mode_i,
  input wire logic [1:0] enable_i,
  input wire logic te_i,
  input wire btf_pkg::btf_daccess_t acc_i,
  output logic hit_o
);
  wire logic type_ok;
  wire logic [31:0] offset;
  wire logic addr_ok;
  wire logic armed;

  // Write-only, read-only, else both directions
  assign type_ok = (mode_i == btf_pkg::DMODE_WRITE_ONLY) ? acc_i.write :
                   (mode_i == btf_pkg::DMODE_READ_ONLY) ? !acc_i.write :
                   1'b1; // RULE3 RULE5 RULE18
  // Any byte of the access hits the stored byte
  assign offset = bp_addr_i - acc_i.addr;
  assign addr_ok = (offset < {27'h0, acc_i.len}); // RULE4
  assign armed = te_i && (enable_i == btf_pkg::BP_FIELD_FAULT); // RULE19
  assign hit_o = acc_i.valid && armed && type_ok && addr_ok; // RULE2 RULE6
endmodule

// >>> btf_ibp_match.sv
// Purpose: One instruction breakpoint channel compare
// Assumes: Instruction pointers are word aligned
// Notes: Reserved mode codes never fire
`timescale 1ns/1ps
module btf_ibp_match (
  input wire logic [31:0] bp_reg_i,
  input wire logic te_i,
  input wire logic valid_i,
  input wire logic [31:0] ip_i,
  output logic hit_o
);
  wire logic [1:0] mode;
  wire logic addr_ok;

  assign mode = {bp_reg_i[btf_pkg::INSTR_BP_MODE_HI], bp_reg_i[btf_pkg::INSTR_BP_MODE_LO]}; // RULE9
  assign addr_ok = bp_reg_i[31:btf_pkg::INSTR_BP_ADDR_LSB] == ip_i[31:btf_pkg::INSTR_BP_ADDR_LSB]; // RULE8
  assign hit_o = valid_i && te_i && (mode == btf_pkg::BP_FIELD_FAULT) && addr_ok; // RULE10
endmodule

// >>> btf_trace_fault.sv
// Purpose: Breakpoint channels and trace-fault generation for the core
// Assumes: Pipeline holds a pending fault until fault_ack_i
// Notes: All inputs come from core logic on sys_clk_i
//
// Operation
// RULE1: Each data channel keeps a full 32-bit byte address to compare.
// RULE2: Data break needs accepted access type and matching address.
// RULE3: Control mode bits pick access types that proceed to address compare.
// RULE4: Any byte covered by the access matching the stored byte hits.
// RULE5: Data breaks on reads only, writes only, or both.
// RULE6: Every data access, explicit or implicit, is checked.
// RULE7: Control-space operation or type faults always reported; trace optional.
// RULE8: Instruction channels compare word address in upper 30 bits.
// RULE9: Low two bits of instruction channel register are its mode.
// RULE10: Instruction break needs trace enable; 00 off, 11 faults.
// RULE11: Instruction registers read by system control only; writable by both.
// RULE12: Stores to instruction registers may hit old or new value briefly.
// RULE13: Listed trace events with trace enable raise a trace fault.
// RULE14: Prereturn detected before execution; others detected on execution.
// RULE15: Prereturn trace is always reported alone.
// RULE16: Merged events may drop some; supervisor and one event always kept.
// RULE17: Others reported first; prereturn serviced after that return.
// RULE18: Data mode 00 writes, 01 both, 10 reads, 11 both.
// RULE19: Data channel needs trace enable; enable 00 off, 11 faults.
// RULE20: New register values act next cycle; reset clears to zero.
`timescale 1ns/1ps
module btf_trace_fault #(
  parameter int DCH = 2,
  parameter int ICH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic trace_enable_flag_i,
  input wire btf_pkg::btf_regreq_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_err_o,
  input wire logic [31:0] breakpoint_control_i,
  input wire btf_pkg::btf_daccess_t data_acc_i,
  input wire logic data_acc_ctl_fault_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_ip_i,
  input wire logic ev_instr_group_i,
  input wire logic ev_fault_call_i,
  input wire logic ev_mark_i,
  input wire logic ev_fmark_i,
  input wire logic ev_supervisor_i,
  input wire logic ev_prereturn_i,
  input wire logic fault_ack_i,
  output logic fault_req_o,
  output logic [btf_pkg::EV_W-1:0] fault_events_o,
  output logic ctl_fault_o,
  output logic [DCH-1:0] data_bp_hit_o,
  output logic [ICH-1:0] instr_bp_hit_o
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_meta;
  logic rst_sync;
  wire logic rst_n;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  assign rst_n = rst_sync;

  // ==========================================================
  // Breakpoint registers
  // ==========================================================
  logic [31:0] data_addr_breakpoint [DCH];
  logic [31:0] instr_addr_breakpoint [ICH];

  wire logic is_ibp0;
  wire logic is_ibp1;
  wire logic is_dbp0;
  wire logic is_dbp1;
  wire logic mapped;
  wire logic wr_ok;
  wire logic rd_denied;

  assign is_ibp0 = reg_req_i.addr == btf_pkg::INSTR_BP_CH0_OFS;
  assign is_ibp1 = reg_req_i.addr == btf_pkg::INSTR_BP_CH1_OFS;
  assign is_dbp0 = reg_req_i.addr == btf_pkg::DATA_BP_CH0_OFS;
  assign is_dbp1 = reg_req_i.addr == btf_pkg::DATA_BP_CH1_OFS;
  assign mapped = is_ibp0 || is_ibp1 || is_dbp0 || is_dbp1;
  assign wr_ok = reg_req_i.valid && reg_req_i.write && mapped;
  // Plain loads of instruction channels are refused
  assign rd_denied = (is_ibp0 || is_ibp1) && !reg_req_i.sysctl; // RULE11

  wire logic [31:0] rd_mux;
  assign rd_mux = is_dbp0 ? data_addr_breakpoint[0] :
                  is_dbp1 ? data_addr_breakpoint[1] :
                  is_ibp0 ? instr_addr_breakpoint[0] :
                  is_ibp1 ? instr_addr_breakpoint[1] : 32'h0000_0000;

  genvar g;
  generate
    for (g = 0; g < DCH; g++) begin : g_dreg
      wire logic sel;
      assign sel = (g == 0) ? is_dbp0 : is_dbp1;
      always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          data_addr_breakpoint[g] <= btf_pkg::BP_RESET_VAL; // RULE20
        end else if (clk_en_i && wr_ok && sel) begin
          data_addr_breakpoint[g] <= reg_req_i.wdata; // RULE1 RULE20
        end
      end
    end
    for (g = 0; g < ICH; g++) begin : g_ireg
      wire logic sel;
      assign sel = (g == 0) ? is_ibp0 : is_ibp1;
      // Word store or system control both write; takes effect next cycle
      always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
          instr_addr_breakpoint[g] <= btf_pkg::BP_RESET_VAL;
        end else if (clk_en_i && wr_ok && sel) begin
          instr_addr_breakpoint[g] <= reg_req_i.wdata; // RULE11 RULE12 RULE20
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
      reg_err_o <= 1'b0;
    end else if (clk_en_i) begin
      reg_rvalid_o <= reg_req_i.valid && !reg_req_i.write && mapped && !rd_denied;
      reg_err_o <= reg_req_i.valid && (!mapped || (!reg_req_i.write && rd_denied));
      reg_rdata_o <= (reg_req_i.valid && !reg_req_i.write && !rd_denied) ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // Channel compares
  // ==========================================================
  wire logic [DCH-1:0] dhit;
  wire logic [ICH-1:0] ihit;

  generate
    for (g = 0; g < DCH; g++) begin : g_dch
      btf_dbp_match u_dm (
        .bp_addr_i(data_addr_breakpoint[g]),
        .mode_i(breakpoint_control_i[btf_pkg::CTL_DATA_MODE_BASE+g*btf_pkg::CTL_CH_STRIDE +: 2]),
        .enable_i(breakpoint_control_i[btf_pkg::CTL_DATA_EN_BASE+g*btf_pkg::CTL_CH_STRIDE +: 2]),
        .te_i(trace_enable_flag_i),
        .acc_i(data_acc_i),
        .hit_o(dhit[g])
      );
    end
    for (g = 0; g < ICH; g++) begin : g_ich
      btf_ibp_match u_im (
        .bp_reg_i(instr_addr_breakpoint[g]),
        .te_i(trace_enable_flag_i),
        .valid_i(instr_valid_i),
        .ip_i(instr_ip_i),
        .hit_o(ihit[g])
      );
    end
  endgenerate

  // ==========================================================
  // Trace event collection
  // ==========================================================
  // Control-space faults always reported; no data trace then
  wire logic dbp_any;
  assign dbp_any = |dhit && !data_acc_ctl_fault_i; // RULE7
  wire logic [btf_pkg::EV_W-1:0] ev_now;
  assign ev_now[btf_pkg::EV_INSTR_GROUP] = trace_enable_flag_i && ev_instr_group_i;
  assign ev_now[btf_pkg::EV_FAULT_CALL] = trace_enable_flag_i && ev_fault_call_i;
  assign ev_now[btf_pkg::EV_MARK] = trace_enable_flag_i && ev_mark_i;
  assign ev_now[btf_pkg::EV_FMARK] = trace_enable_flag_i && ev_fmark_i;
  assign ev_now[btf_pkg::EV_IBP] = |ihit;
  assign ev_now[btf_pkg::EV_DBP] = dbp_any;
  assign ev_now[btf_pkg::EV_SUPERVISOR] = trace_enable_flag_i && ev_supervisor_i;
  // Prereturn is flagged before the traced instruction runs
  assign ev_now[btf_pkg::EV_PRERETURN] = trace_enable_flag_i && ev_prereturn_i; // RULE14

  wire logic [btf_pkg::EV_W-1:0] other_mask;
  assign other_mask = ~({{(btf_pkg::EV_W-1){1'b0}}, 1'b1} << btf_pkg::EV_PRERETURN);
  wire logic [btf_pkg::EV_W-1:0] other_now;
  assign other_now = ev_now & other_mask; // RULE13

  // ==========================================================
  // Fault record sequencer
  // ==========================================================
  btf_pkg::btf_state_t state;
  btf_pkg::btf_state_t next_state;
  logic [btf_pkg::EV_W-1:0] other_acc;
  logic preret_pend;
  logic [btf_pkg::EV_W-1:0] next_other_acc;
  logic next_preret_pend;

  always_comb begin
    next_state = state;
    next_other_acc = other_acc;
    next_preret_pend = preret_pend || ev_now[btf_pkg::EV_PRERETURN];
    case (state)
      btf_pkg::BTF_IDLE: begin
        // Other events seen in idle merge into one record; those arriving while a record is pending are dropped
        next_other_acc = other_acc | other_now; // RULE16
        if (|next_other_acc) begin
          next_state = btf_pkg::BTF_REPORT; // RULE17
        end else if (next_preret_pend) begin
          next_state = btf_pkg::BTF_PRERET; // RULE15
        end
      end
      btf_pkg::BTF_REPORT: begin
        if (fault_ack_i) begin
          next_other_acc = '0;
          next_state = next_preret_pend ? btf_pkg::BTF_PRERET : btf_pkg::BTF_IDLE; // RULE17
        end
      end
      btf_pkg::BTF_PRERET: begin
        if (fault_ack_i) begin
          next_preret_pend = 1'b0;
          next_state = btf_pkg::BTF_IDLE;
        end
      end
      default: begin
        next_state = btf_pkg::BTF_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= btf_pkg::BTF_IDLE;
      other_acc <= '0;
      preret_pend <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      other_acc <= next_other_acc;
      preret_pend <= next_preret_pend;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_events_o <= '0;
      ctl_fault_o <= 1'b0;
      data_bp_hit_o <= '0;
      instr_bp_hit_o <= '0;
    end else if (clk_en_i) begin
      ctl_fault_o <= data_acc_i.valid && data_acc_ctl_fault_i; // RULE7
      data_bp_hit_o <= dhit;
      instr_bp_hit_o <= ihit;
      case (next_state)
        btf_pkg::BTF_REPORT: fault_events_o <= next_other_acc; // RULE16
        btf_pkg::BTF_PRERET: fault_events_o <= {1'b1, {(btf_pkg::EV_W-1){1'b0}}}; // RULE15
        default: fault_events_o <= '0;
      endcase
    end
  end

  assign fault_req_o = (state == btf_pkg::BTF_REPORT) || (state == btf_pkg::BTF_PRERET); // RULE13
endmodule

// >>> btf_trace_fault_assertions.sv
// Purpose: Port checks for breakpoint and trace-fault logic
// Assumes: Clock enable held high
// Notes: Bound to every btf_trace_fault
`timescale 1ns/1ps
module btf_trace_fault_assertions #(
  parameter int DCH = 2,
  parameter int ICH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic trace_enable_flag_i,
  input wire btf_pkg::btf_regreq_t reg_req_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic reg_err_o,
  input wire logic [31:0] breakpoint_control_i,
  input wire btf_pkg::btf_daccess_t data_acc_i,
  input wire logic data_acc_ctl_fault_i,
  input wire logic instr_valid_i,
  input wire logic ev_mark_i,
  input wire logic ev_supervisor_i,
  input wire logic fault_ack_i,
  input wire logic fault_req_o,
  input wire logic [btf_pkg::EV_W-1:0] fault_events_o,
  input wire logic ctl_fault_o,
  input wire logic [DCH-1:0] data_bp_hit_o,
  input wire logic [ICH-1:0] instr_bp_hit_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Assertions
  // ==========================================================
  logic type_ok;
  assign type_ok = breakpoint_control_i[17:16] == 2'h3 && (data_acc_i.write ?
    breakpoint_control_i[19:18] != 2'h2 : breakpoint_control_i[19:18] != 2'h0);
  AST_IREAD_REFUSED: assert property (
    reg_req_i.valid && !reg_req_i.write && !reg_req_i.sysctl && reg_req_i.addr[15:3] == 13'h1080
    |=> reg_err_o && reg_rdata_o == 32'h0) else $error("plain instr read not refused");
  AST_RVALID_CAUSE: assert property (
    reg_rvalid_o |-> $past(reg_req_i.valid && !reg_req_i.write)) else $error("stray rvalid");
  AST_DBP_TE: assert property (
    |data_bp_hit_o |-> $past(trace_enable_flag_i)) else $error("data hit without te");
  AST_DBP_TYPE: assert property (
    data_bp_hit_o[0] |-> $past(data_acc_i.valid && type_ok)) else $error("data hit bad type");
  AST_IBP_TE: assert property (
    |instr_bp_hit_o |-> $past(trace_enable_flag_i && instr_valid_i)) else $error("instr hit");
  AST_PRERET_ALONE: assert property (
    fault_req_o && fault_events_o[7] |-> fault_events_o == 8'h80) else $error("prereturn merged");
  AST_RECORD_HOLDS: assert property (
    fault_req_o && !fault_ack_i |=> fault_req_o && $stable(fault_events_o))
    else $error("record changed");
  AST_MARK_RAISES: assert property (
    trace_enable_flag_i && ev_mark_i && !fault_req_o |=> fault_req_o && fault_events_o[2])
    else $error("mark not raised");
  AST_SUPERVISOR_KEPT: assert property (
    trace_enable_flag_i && ev_supervisor_i && !fault_req_o |=> fault_events_o[6])
    else $error("supervisor dropped");
  AST_CTL_FAULT: assert property (
    data_acc_i.valid && data_acc_ctl_fault_i |=> ctl_fault_o) else $error("ctl fault lost");
  AST_DBP_FAULT: assert property (
    data_bp_hit_o[0] && !ctl_fault_o && !$past(fault_req_o) |-> fault_req_o && fault_events_o[5])
    else $error("data hit without record");
  cover property (fault_req_o && fault_events_o == 8'h80);
  cover property (reg_err_o);
  cover property (|instr_bp_hit_o);
endmodule
bind btf_trace_fault btf_trace_fault_assertions #(.DCH(DCH), .ICH(ICH)) i_chk (
  .sys_clk_i, .rst_n_i, .trace_enable_flag_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o,
  .reg_err_o, .breakpoint_control_i, .data_acc_i, .data_acc_ctl_fault_i, .instr_valid_i,
  .ev_mark_i, .ev_supervisor_i, .fault_ack_i, .fault_req_o, .fault_events_o, .ctl_fault_o,
  .data_bp_hit_o, .instr_bp_hit_o);

// >>> btf_core_model.sv
// Purpose: Pipeline side that takes trace fault records
// Assumes: One record pending at a time
// Notes: lat_i cycles of delay before each acknowledge
`timescale 1ns/1ps
module btf_core_model (
  input wire logic clk_i,
  input wire logic fault_req_i,
  input wire logic [7:0] events_i,
  input wire logic [3:0] lat_i,
  output logic fault_ack_o,
  output logic [7:0] rec_o,
  output logic [7:0] rec_cnt_o
);
  logic [3:0] wait_q = 4'h0;
  initial begin
    fault_ack_o = 1'b0;
    rec_o = 8'h0;
    rec_cnt_o = 8'h0;
  end
  always @(posedge clk_i) begin
    fault_ack_o <= 1'b0;
    if (fault_req_i && !fault_ack_o) begin
      if (wait_q >= lat_i) begin
        fault_ack_o <= 1'b1;
        rec_o <= events_i;
        rec_cnt_o <= rec_cnt_o + 8'h1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// >>> btf_trace_fault_tb.sv
// Purpose: Self-checking bench for breakpoint and trace-fault logic
// Assumes: Clock enable high except in its own test
// Notes: Row table covers data compare and modes
`timescale 1ns/1ps
module btf_trace_fault_tb;
  typedef struct packed {
    logic [3:0] ctl;
    logic wr;
    logic [7:0] lo;
    logic [4:0] len;
    logic hit;
  } btf_row_t;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic te = 1'b0;
  logic cfault = 1'b0;
  logic ivalid = 1'b0;
  logic [31:0] ip = 32'h0;
  logic [31:0] ctl = 32'h0;
  logic [5:0] ev = 6'h0;
  logic [3:0] lat = 4'h0;
  logic ce = 1'b1;
  btf_pkg::btf_regreq_t req = '0;
  btf_pkg::btf_daccess_t acc = '0;
  logic ack, rvalid, rerr, freq, cf;
  logic [31:0] rdata, rd;
  logic [7:0] fev, rec, rec_cnt, n;
  logic [1:0] dhit, ihit;
  int mismatches = 0;
  int checked = 0;
  btf_row_t rows [14];
  btf_trace_fault i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(ce),
    .trace_enable_flag_i(te), .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .reg_err_o(rerr), .breakpoint_control_i(ctl), .data_acc_i(acc),
    .data_acc_ctl_fault_i(cfault), .instr_valid_i(ivalid), .instr_ip_i(ip),
    .ev_instr_group_i(ev[0]), .ev_fault_call_i(ev[1]), .ev_mark_i(ev[2]), .ev_fmark_i(ev[3]),
    .ev_supervisor_i(ev[4]), .ev_prereturn_i(ev[5]), .fault_ack_i(ack), .fault_req_o(freq),
    .fault_events_o(fev), .ctl_fault_o(cf), .data_bp_hit_o(dhit), .instr_bp_hit_o(ihit));
  btf_core_model i_core (.clk_i(sys_clk_i), .fault_req_i(freq), .events_i(fev), .lat_i(lat),
    .fault_ack_o(ack), .rec_o(rec), .rec_cnt_o(rec_cnt));
  initial begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_op(input logic w, input logic sc, input logic [15:0] a,
                        input logic [31:0] d);
    @(posedge sys_clk_i);
    req <= '{1'b1, w, sc, a, d};
    @(posedge sys_clk_i);
    req.valid <= 1'b0;
    #1;
    rd = rdata;
  endtask
  task automatic dacc(input logic [31:0] c, input logic w, input logic [31:0] a,
                      input logic [4:0] l, input logic f);
    @(posedge sys_clk_i);
    ctl <= c;
    cfault <= f;
    acc <= '{1'b1, w, a, l};
    @(posedge sys_clk_i);
    acc.valid <= 1'b0;
    cfault <= 1'b0;
    #1;
  endtask
  task automatic instr(input logic v, input logic [31:0] a);
    @(posedge sys_clk_i);
    te <= v;
    ivalid <= 1'b1;
    ip <= a;
    @(posedge sys_clk_i);
    ivalid <= 1'b0;
    #1;
  endtask
  task automatic pulse(input logic v, input logic [5:0] e);
    for (int k = 0; k < 40 && freq; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
    n = rec_cnt;
    @(posedge sys_clk_i);
    te <= v;
    ev <= e;
    @(posedge sys_clk_i);
    ev <= 6'h0;
  endtask
  task automatic wait_rec(input logic [7:0] t);
    for (int k = 0; k < 40 && rec_cnt !== t; k++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    rows = '{'{4'hb, 1'b0, 8'h0f, 5'h01, 1'b1}, '{4'hb, 1'b0, 8'h0e, 5'h02, 1'b1},
      '{4'hb, 1'b0, 8'h0c, 5'h04, 1'b1}, '{4'hb, 1'b0, 8'h0d, 5'h04, 1'b1},
      '{4'hb, 1'b0, 8'h08, 5'h08, 1'b1}, '{4'hb, 1'b0, 8'h00, 5'h10, 1'b1},
      '{4'hb, 1'b0, 8'h00, 5'h0c, 1'b0}, '{4'hb, 1'b0, 8'h10, 5'h04, 1'b0},
      '{4'hb, 1'b1, 8'h0f, 5'h01, 1'b0}, '{4'h3, 1'b0, 8'h0f, 5'h01, 1'b0},
      '{4'h3, 1'b1, 8'h0c, 5'h04, 1'b1}, '{4'h7, 1'b1, 8'h0f, 5'h01, 1'b1},
      '{4'hf, 1'b0, 8'h0f, 5'h01, 1'b1}, '{4'h8, 1'b0, 8'h0f, 5'h01, 1'b0}};
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    reg_op(1'b0, 1'b1, 16'h8424, 32'h0);
    check(rd, 32'h0);
    reg_op(1'b1, 1'b0, 16'h8420, 32'h100f);
    reg_op(1'b1, 1'b0, 16'h8400, 32'h3003);
    reg_op(1'b1, 1'b1, 16'h8404, 32'h4000);
    reg_op(1'b1, 1'b0, 16'h8410, 32'hffff);
    check(rerr, 1'b1);
    reg_op(1'b0, 1'b0, 16'h8420, 32'h0);
    check({rvalid, rd}, {1'b1, 32'h100f});
    reg_op(1'b0, 1'b0, 16'h8400, 32'h0);
    check({rerr, rd}, {1'b1, 32'h0});
    reg_op(1'b0, 1'b1, 16'h8400, 32'h0);
    check(rd, 32'h3003);
    $display("test regs done");
    te <= 1'b1;
    foreach (rows[i]) begin
      dacc({12'h0, rows[i].ctl, 16'h0}, rows[i].wr, {24'h10, rows[i].lo}, rows[i].len, 1'b0);
      check(dhit[0], rows[i].hit);
    end
    dacc(32'h000b0000, 1'b0, 32'h8420, 5'h04, 1'b1);
    check(cf, 1'b1);
    @(posedge sys_clk_i);
    te <= 1'b0;
    dacc(32'h000b0000, 1'b0, 32'h100f, 5'h01, 1'b0);
    check(dhit, 2'b00);
    @(posedge sys_clk_i);
    te <= 1'b1;
    req <= '{1'b1, 1'b1, 1'b0, 16'h8424, 32'h2000};
    dacc(32'h00f00000, 1'b1, 32'h2000, 5'h01, 1'b0);
    req.valid <= 1'b0;
    check(dhit, 2'b10);
    $display("test data done");
    instr(1'b1, 32'h3000);
    check(ihit, 2'b01);
    instr(1'b1, 32'h3004);
    check(ihit, 2'b00);
    instr(1'b1, 32'h4000);
    check(ihit, 2'b00);
    instr(1'b0, 32'h3000);
    check(ihit, 2'b00);
    $display("test instr done");
    lat <= 4'h3;
    for (int b = 0; b < 4; b++) begin
      pulse(1'b1, 6'h01 << b);
      wait_rec(n + 8'h1);
      check(rec, 8'h01 << b);
    end
    pulse(1'b0, 6'h04);
    repeat (6) @(posedge sys_clk_i);
    check(rec_cnt, n);
    pulse(1'b1, 6'h34);
    wait_rec(n + 8'h1);
    check({rec[7], rec[6]}, 2'b01);
    wait_rec(n + 8'h2);
    check(rec, 8'h80);
    $display("test trace done");
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check({freq, dhit, ihit}, 5'h0);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    reg_op(1'b0, 1'b1, 16'h8420, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    @(posedge sys_clk_i);
    ce <= 1'b0;
    reg_op(1'b1, 1'b1, 16'h8420, 32'h5555);
    check({rvalid, rerr}, 2'b00);
    ce <= 1'b1;
    reg_op(1'b0, 1'b1, 16'h8420, 32'h0);
    check({rvalid, rd}, {1'b1, 32'h0});
    $display("test enable done");
    report_and_stop();
  end
endmodule
